/* src/cpe_regs.sv */
/*
 * charger emulation profile enable bank: one standard-profile register
 * and one legacy-profile register on a classic wishbone slave, and the
 * profile eligibility they steer.
 * assumes one clock, synchronous reset, and that the emulation cycle
 * logic outside reads the eligibility outputs.
 */
// Summary of operation
// - bit four withholds dcp profile from cycle
// - dedicated dcp mode overrides the disable bit
// - disable bit set: dcp profile withheld unless in dedicated mode
// - disable bit clear: dcp profile included
// - legacy bit n-1 withholds legacy profile n
// - legacy bits zero: eligible; reset to zero
// - both registers keep contents through sleep
`timescale 1ns/1ns
`include "cpe_map.svh"

module cpe_regs
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        mode_select_pin_a_i,
    input  wire logic        mode_select_pin_b_i,
    input  wire logic        emulation_allow_i,
    input  wire logic        sleep_i,
    output logic             dedicated_mode_o,
    output logic             dcp_profile_allow_o,
    output logic      [6:0]  legacy_profile_allow_o
);

    cpe_pkg::cpe_wb_req_s  req;
    cpe_pkg::cpe_reg_e     reg_sel;
    cpe_pkg::cpe_profile_s allow_d;
    cpe_pkg::cpe_profile_s allow_q;
    logic                  take;
    logic                  wr;
    logic                  dedicated;
    logic [7:0]            std_d;
    logic [7:0]            std_q;
    logic [7:0]            leg_d;
    logic [7:0]            leg_q;
    logic [31:0]           rdata_d;
    logic [31:0]           rdata_q;
    logic                  dedicated_q;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

    cpe_wb_slave u_slave
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .req_i  (req),
        .take_o (take),
        .wr_o   (wr),
        .reg_o  (reg_sel),
        .ack_o  (wb_ack_o)
    );

    // register contents: only bus writes and reset change them, so sleep leaves
    // them as they are
    always_comb
    begin
        std_d = std_q;
        leg_d = leg_q;
        if (wr && reg_sel == cpe_pkg::CPE_REG_STD)
            std_d = req.dat[7:0] & `CPE_STD_MASK;
        if (wr && reg_sel == cpe_pkg::CPE_REG_LEG)
            leg_d = req.dat[7:0] & `CPE_LEG_MASK;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            std_q <= `CPE_STD_RESET;
            leg_q <= `CPE_LEG_RESET;
        end
        else
        begin
            std_q <= std_d;
            leg_q <= leg_d;
        end
    end

    // read data is captured when the request is taken, so it stands
    // in a flop for the whole ack cycle
    always_comb
    begin
        rdata_d = rdata_q;
        if (take)
        begin
            case (reg_sel)
                cpe_pkg::CPE_REG_STD:
                    rdata_d = {24'h000000, std_q};
                cpe_pkg::CPE_REG_LEG:
                    rdata_d = {24'h000000, leg_q};
                default:
                    rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= rdata_d;
    end

    assign wb_dat_o = rdata_q;

    // profile eligibility; mode pins are taken as synchronous
    assign dedicated = emulation_allow_i &&
        ({mode_select_pin_a_i, mode_select_pin_b_i} == `CPE_DCP_MODE_PINS);

    always_comb
    begin
        // dedicated mode wins: the disable bit would otherwise leave
        // the port with no profile at all
        allow_d.dcp    = dedicated ||
                         !std_q[`CPE_DCP_DIS_BIT];
        allow_d.legacy = ~leg_q[`CPE_LEG_MSB:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            allow_q     <= '0;
            dedicated_q <= 1'b0;
        end
        else
        begin
            allow_q     <= allow_d;
            dedicated_q <= dedicated;
        end
    end

    assign dcp_profile_allow_o    = allow_q.dcp;
    assign legacy_profile_allow_o = allow_q.legacy;
    assign dedicated_mode_o       = dedicated_q;

    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (rst_i);

    chk_dcp_withheld: assert property (
        !dedicated && std_q[`CPE_DCP_DIS_BIT] |=> !dcp_profile_allow_o)
        else $error("dcp profile allowed while disabled");

    chk_dcp_included: assert property (
        !std_q[`CPE_DCP_DIS_BIT] |=> dcp_profile_allow_o)
        else $error("dcp profile withheld while enabled");

    chk_mode_override: assert property (
        dedicated |=> dcp_profile_allow_o && dedicated_mode_o)
        else $error("dedicated mode did not override disable");

    chk_dcp_bit_write: assert property (
        wr && reg_sel == cpe_pkg::CPE_REG_STD && !dedicated
        ##1 !dedicated
        |=> dcp_profile_allow_o == !$past(req.dat[`CPE_DCP_DIS_BIT], 2))
        else $error("dcp disable write not reflected");

    chk_legacy_map: assert property (
        wr && reg_sel == cpe_pkg::CPE_REG_LEG
        |=> ##1 legacy_profile_allow_o == ~$past(req.dat[6:0], 2))
        else $error("legacy disable bit maps to wrong profile");

    chk_legacy_reset: assert property (
        $past(rst_i) |-> leg_q == `CPE_LEG_RESET && allow_d.legacy == 7'h7f)
        else $error("legacy profiles not enabled after reset");

    chk_rsvd_kept: assert property (
        wr && reg_sel == cpe_pkg::CPE_REG_STD
        |=> std_q[`CPE_RSVD_MSB:0] == $past(req.dat[`CPE_RSVD_MSB:0]))
        else $error("reserved bits not stored as written");

    chk_sleep_hold: assert property (
        sleep_i && !wr |=> $stable(std_q) && $stable(leg_q))
        else $error("register changed during sleep");

    chk_unimpl_zero: assert property (
        wb_ack_o && !req.we |-> wb_dat_o[31:8] == 24'h000000 &&
        (reg_sel != cpe_pkg::CPE_REG_STD || wb_dat_o[7:5] == 3'h0) &&
        (reg_sel != cpe_pkg::CPE_REG_STD || wb_dat_o[3] == 1'b0) &&
        (reg_sel != cpe_pkg::CPE_REG_LEG || wb_dat_o[7] == 1'b0))
        else $error("unimplemented bits read nonzero");

    chk_ack_timing: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not given one cycle after request");

    cov_dcp_write: cover property (
        wr && reg_sel == cpe_pkg::CPE_REG_STD
        && req.dat[`CPE_DCP_DIS_BIT]);

    cov_override: cover property (
        std_q[`CPE_DCP_DIS_BIT] && dedicated);

    cov_legacy_all_off: cover property (
        leg_q == `CPE_LEG_MASK ##1 sleep_i);

    cov_unmapped: cover property (
        take && reg_sel == cpe_pkg::CPE_REG_NONE);

endmodule // cpe_regs

/* src/cpe_map.svh */
/*
 * register map, field positions and reset values of the charger
 * emulation profile enable bank.
 * assumes a 32-bit classic wishbone slave, one register per word.
 */
`ifndef CPE_MAP_SVH
`define CPE_MAP_SVH

// printed register indices; byte address is four times the index
`define CPE_STD_INDEX      8'h20
`define CPE_LEG_INDEX      8'h21
`define CPE_STD_ADDR       {`CPE_STD_INDEX, 2'b00}
`define CPE_LEG_ADDR       {`CPE_LEG_INDEX, 2'b00}

`define CPE_STD_RESET      8'h16
`define CPE_LEG_RESET      8'h00
`define CPE_STD_MASK       8'h17
`define CPE_LEG_MASK       8'h7f

`define CPE_DCP_DIS_BIT    4
`define CPE_RSVD_MSB       2
`define CPE_LEG_MSB        6

// mode pin pattern {pin_a, pin_b} that selects dedicated dcp mode
`define CPE_DCP_MODE_PINS  2'b11

`endif

/* src/cpe_pkg.sv */
/*
 * types shared by the profile enable bank and its bus slave.
 * assumes cpe_map.svh supplies the numeric constants.
 */
package cpe_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [9:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } cpe_wb_req_s;

    typedef struct packed {
        logic       dcp;
        logic [6:0] legacy;
    } cpe_profile_s;

    typedef enum logic [1:0] {
        CPE_REG_NONE,
        CPE_REG_STD,
        CPE_REG_LEG
    } cpe_reg_e;

    typedef enum logic {
        CPE_IDLE,
        CPE_ACK
    } cpe_bus_e;

endpackage

/* src/cpe_wb_slave.sv */
/*
 * classic wishbone slave front end: decodes the address, answers every
 * request with a one-cycle ack one edge after it is taken.
 * assumes the master holds its request until it samples ack.
 */
`timescale 1ns/1ns
`include "cpe_map.svh"

module cpe_wb_slave
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire cpe_pkg::cpe_wb_req_s req_i,
    output logic                     take_o,
    output logic                     wr_o,
    output cpe_pkg::cpe_reg_e        reg_o,
    output logic                     ack_o
);

    cpe_pkg::cpe_bus_e state_d;
    cpe_pkg::cpe_bus_e state_q;

    always_comb
    begin
        if (req_i.adr == `CPE_STD_ADDR)
            reg_o = cpe_pkg::CPE_REG_STD;
        else if (req_i.adr == `CPE_LEG_ADDR)
            reg_o = cpe_pkg::CPE_REG_LEG;
        else
            reg_o = cpe_pkg::CPE_REG_NONE;
    end

    always_comb
    begin
        take_o  = 1'b0;
        state_d = state_q;
        case (state_q)
            cpe_pkg::CPE_IDLE:
            begin
                if (req_i.cyc && req_i.stb)
                begin
                    take_o  = 1'b1;
                    state_d = cpe_pkg::CPE_ACK;
                end
            end
            cpe_pkg::CPE_ACK:
                state_d = cpe_pkg::CPE_IDLE;
            default:
                state_d = cpe_pkg::CPE_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_q <= cpe_pkg::CPE_IDLE;
        else
            state_q <= state_d;
    end

    assign ack_o = (state_q == cpe_pkg::CPE_ACK);
    // the write lands on the edge where the master samples ack;
    // only byte lane 0 carries register bits
    assign wr_o  = ack_o && req_i.we && req_i.sel[0];

endmodule // cpe_wb_slave

/* tb/cpe_regs_tb_top.sv */
/*
 * self-checking bench for the profile enable bank: table of register
 * writes with readback and eligibility, then mode, sleep and reset cases.
 * assumes the one-cycle ack and one-cycle output lag of cpe_regs.
 */
`timescale 1ns/1ns
`include "cpe_map.svh"

module cpe_regs_tb_top;

    typedef struct packed {
        logic [9:0] adr;
        logic [7:0] wdat;
        logic [7:0] rdat;
        logic       dcp;
        logic [6:0] leg;
    } cpe_row_s;

    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        pin_a    = 1'b0;
    logic        pin_b    = 1'b0;
    logic        emu      = 1'b0;
    logic        sleep_i  = 1'b0;
    logic        dedicated_mode_o;
    logic        dcp_profile_allow_o;
    logic [6:0]  legacy_profile_allow_o;
    logic [31:0] rd;
    int          fail_count   = 0;
    int          total_checks = 0;
    int          cycle_count  = 0;
    cpe_row_s    rows [6];

    cpe_regs DUT
    (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .wb_cyc_i               (wb_cyc_i),
        .wb_stb_i               (wb_stb_i),
        .wb_we_i                (wb_we_i),
        .wb_adr_i               (wb_adr_i),
        .wb_sel_i               (wb_sel_i),
        .wb_dat_i               (wb_dat_i),
        .wb_dat_o               (wb_dat_o),
        .wb_ack_o               (wb_ack_o),
        .mode_select_pin_a_i    (pin_a),
        .mode_select_pin_b_i    (pin_b),
        .emulation_allow_i      (emu),
        .sleep_i                (sleep_i),
        .dedicated_mode_o       (dedicated_mode_o),
        .dcp_profile_allow_o    (dcp_profile_allow_o),
        .legacy_profile_allow_o (legacy_profile_allow_o)
    );

    always #5 clk_i = ~clk_i;

    // the whole run needs well under a thousand cycles
    always @(posedge clk_i)
    begin
        cycle_count++;
        if (cycle_count == 5000)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wb(logic we, logic [9:0] adr, logic [7:0] d,
                      logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, d};
        // no local limit: only the bench timeout ends a hung wait
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk("ack_wait", n, 32'h2);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rdc(string name, logic [9:0] adr, logic [7:0] exp);
        wb(1'b0, adr, 8'h00, 4'h1);
        chk(name, rd, {24'h0, exp});
    endtask

    task automatic outs(logic dcp, logic [6:0] leg);
        repeat (2) @(posedge clk_i);
        #1;
        chk("dcp_allow", {31'h0, dcp_profile_allow_o}, {31'h0, dcp});
        chk("leg_allow", {25'h0, legacy_profile_allow_o}, {25'h0, leg});
    endtask

    task automatic mode(logic e, logic [1:0] pins, logic exp);
        @(posedge clk_i);
        emu   <= e;
        pin_a <= pins[1];
        pin_b <= pins[0];
        outs(exp, 7'h7f);
        chk("dedicated", {31'h0, dedicated_mode_o}, {31'h0, exp});
    endtask

    initial
    begin
        rows[0] = {`CPE_STD_ADDR, 8'hff, 8'h17, 1'b0, 7'h7f};
        rows[1] = {`CPE_STD_ADDR, 8'h06, 8'h06, 1'b1, 7'h7f};
        rows[2] = {`CPE_LEG_ADDR, 8'hff, 8'h7f, 1'b1, 7'h00};
        rows[3] = {`CPE_LEG_ADDR, 8'h55, 8'h55, 1'b1, 7'h2a};
        rows[4] = {10'h088, 8'hff, 8'h00, 1'b1, 7'h2a};
        rows[5] = {`CPE_LEG_ADDR, 8'h00, 8'h00, 1'b1, 7'h7f};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        outs(1'b0, 7'h7f);
        rdc("std_reset", `CPE_STD_ADDR, `CPE_STD_RESET);
        rdc("leg_reset", `CPE_LEG_ADDR, `CPE_LEG_RESET);
        foreach (rows[i])
        begin
            wb(1'b1, rows[i].adr, rows[i].wdat, 4'h1);
            rdc("row_read", rows[i].adr, rows[i].rdat);
            outs(rows[i].dcp, rows[i].leg);
        end
        // a write without the low byte lane must leave the register alone
        wb(1'b1, `CPE_LEG_ADDR, 8'h7f, 4'he);
        rdc("sel_read", `CPE_LEG_ADDR, 8'h00);
        wb(1'b0, `CPE_STD_ADDR, 8'h00, 4'h1);
        wb(1'b1, `CPE_STD_ADDR, (rd[7:0] & 8'h07) | 8'h10, 4'h1);
        mode(1'b1, `CPE_DCP_MODE_PINS, 1'b1);
        mode(1'b0, `CPE_DCP_MODE_PINS, 1'b0);
        mode(1'b1, 2'b10, 1'b0);
        wb(1'b1, `CPE_LEG_ADDR, 8'h2b, 4'h1);
        @(posedge clk_i);
        sleep_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rdc("std_sleep", `CPE_STD_ADDR, 8'h16);
        rdc("leg_sleep", `CPE_LEG_ADDR, 8'h2b);
        outs(1'b0, 7'h54);
        @(posedge clk_i);
        sleep_i <= 1'b0;
        rst_i   <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("leg_rerst", `CPE_LEG_ADDR, `CPE_LEG_RESET);
        rdc("std_rerst", `CPE_STD_ADDR, `CPE_STD_RESET);
        outs(1'b0, 7'h7f);
        report_and_stop();
    end

endmodule // cpe_regs_tb_top
